/* File: src/overtemp_fault_limit_response.sv */
// Behaviour
// RL1: Threshold command 4Fh, word write and word read, degrees Celsius.
// RL2: Digital comparator checks die temperature against selected threshold.
// RL3: Threshold bits 15:11 read-only exponent 00010b, 4 degrees per step.
// RL4: Threshold bits 10:6 reserved, read-only, always read zero.
// RL5: Threshold bits 5:0 writable mantissa, restored, default means 145 C.
// RL6: Mantissa reads back as written; applied threshold is nearest setting.
// RL7: Bins <30:115 30:120 31:125 32-33:130 34:135 35:140 36:145 else 150.
// RL8: Restore loads a fixed mantissa for each supported setting.
// RL9: Write changing bits 15:6 is NACKed, ignored, sets cml and ivd.
// RL10: Response command 50h, byte write and byte read.
// RL11: On fault act per retry, set fault flag, assert alert.
// RL12: Response bit 7 read-only one; output always shuts down first.
// RL13: Response bit 6 read-only zero.
// RL14: Retry 000b latches off until enable toggles.
// RL15: Retry 111b restarts after 52 ms, endlessly.
// RL16: Other retry values are rejected as invalid data.
// RL17: Only retry bit 5 is stored; field rebuilt from it.
// RL18: Bits 2:0 mirror the retry selection, reset 000b.
// RL19: Fault when temperature at or above threshold; writes apply at once.
// RL20: Host writes only 000b or 111b with fixed bits consistent.
`timescale 1ns/1ns
module overtemp_fault_limit_response #(
  parameter int RETRY_CYCLES = otf_pkg::RETRY_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               lnk_clk,
  input  wire logic               lnk_rstn,
  input  wire logic               lnk_valid,
  input  otf_pkg::link_req_t      lnk_req,
  output logic                    lnk_busy,
  output logic                    lnk_done,
  output otf_pkg::link_rsp_t      lnk_rsp,
  input  wire logic [7:0]         die_temp,
  input  wire logic               en_pin,
  input  wire logic               nvm_load,
  input  wire logic [2:0]         nvm_setting,
  input  wire logic               nvm_retry_bit,
  input  wire logic               clear_faults,
  output logic                    out_enable,
  output logic                    fault_shutdown,
  output logic                    overtemp_fault_flag,
  output logic                    cml_flag,
  output logic                    ivd_flag,
  output logic                    alert_out,
  output logic                    alert_oe,
  output logic [7:0]              thr_applied_degc
);

  localparam int CW = $clog2(RETRY_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(RETRY_CYCLES - 1);

  typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_HICCUP} state_t;

  otf_pkg::link_req_t req;
  otf_pkg::link_rsp_t rsp_ff, nxt_rsp;
  logic        req_pulse, rsp_pulse_ff, nxt_rsp_pulse;
  logic [5:0]  mant_ff, nxt_mant;
  logic        retry_bit_ff, nxt_retry_bit;
  logic        otf_ff, nxt_otf, cml_ff, nxt_cml, ivd_ff, nxt_ivd;
  logic        bad_write;
  logic [15:0] thr_word;
  logic [7:0]  act_byte;
  logic [2:0]  wr_sel;
  logic [2:0]  bin_idx;
  logic [7:0]  thr_degc;
  logic        en_meta_ff, en_ff;
  logic        hot, trip;
  state_t      st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic        out_en_ff, nxt_out_en, shut_ff, nxt_shut, alert_ff;
  logic [7:0]  deg_ff;
  logic [7:0]  last_cmd_ff;
  logic        last_wr_ff;

  cmd_cross u_cross (
    .clk       (clk),
    .rstn      (rstn),
    .lnk_clk   (lnk_clk),
    .lnk_rstn  (lnk_rstn),
    .lnk_valid (lnk_valid),
    .lnk_req   (lnk_req),
    .lnk_busy  (lnk_busy),
    .lnk_done  (lnk_done),
    .lnk_rsp   (lnk_rsp),
    .req_pulse (req_pulse),
    .req       (req),
    .rsp_pulse (rsp_pulse_ff),
    .rsp       (rsp_ff)
  );

  ot_bin u_bin (
    .mant (mant_ff),
    .idx  (bin_idx),
    .degc (thr_degc)
  );

  // Enable pin comes from outside; two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_meta_ff <= 1'h0;
      en_ff      <= 1'h0;
    end else begin
      en_meta_ff <= en_pin;
      en_ff      <= en_meta_ff;
    end
  end

  // Read images; fixed fields are constants, not storage
  always_comb begin
    thr_word = {otf_pkg::THR_EXP, otf_pkg::THR_RSV, mant_ff}; // [RL3] [RL4]
    act_byte = {otf_pkg::ACT_FIXED, {3{retry_bit_ff}},
                {3{retry_bit_ff}}};                    // [RL12] [RL13] [RL18]
    wr_sel   = req.wdata[otf_pkg::ACT_SEL_LSB +: 3];
  end

  // Command decode, flags and restore
  always_comb begin
    nxt_mant      = mant_ff;
    nxt_retry_bit = retry_bit_ff;
    nxt_rsp       = rsp_ff;
    nxt_rsp_pulse = 1'h0;
    bad_write     = 1'h0;
    if (req_pulse) begin
      nxt_rsp_pulse = 1'h1;
      nxt_rsp       = '0;
      case (req.cmd)
        otf_pkg::CMD_THRESHOLD: begin                   // [RL1]
          if (!req.word) begin
            bad_write = req.write;
          end else if (!req.write) begin
            nxt_rsp.ack   = 1'h1;
            nxt_rsp.rdata = thr_word;
          end else if (req.wdata[15:otf_pkg::THR_RSV_LSB] !=
                       thr_word[15:otf_pkg::THR_RSV_LSB]) begin
            bad_write = 1'h1;                           // [RL9]
          end else begin
            nxt_rsp.ack = 1'h1;
            nxt_mant    = req.wdata[5:0];               // [RL5] [RL6]
          end
        end
        otf_pkg::CMD_ACTION: begin                      // [RL10]
          if (req.word) begin
            bad_write = req.write;
          end else if (!req.write) begin
            nxt_rsp.ack   = 1'h1;
            nxt_rsp.rdata = {8'h00, act_byte};
          end else if ((wr_sel != otf_pkg::RETRY_LATCH &&
                        wr_sel != otf_pkg::RETRY_AUTO) ||
                       req.wdata[15:8] != 8'h00 ||
                       req.wdata[7:otf_pkg::ACT_FIX_LSB] !=
                         otf_pkg::ACT_FIXED ||
                       req.wdata[otf_pkg::ACT_DLY_LSB +: 3] !=
                         wr_sel) begin
            bad_write = 1'h1;                           // [RL16] [RL20]
          end else begin
            nxt_rsp.ack   = 1'h1;
            nxt_retry_bit = wr_sel[2];                  // [RL17]
          end
        end
        default: begin
          nxt_rsp.ack = 1'h0;
        end
      endcase
    end
    // Restore is a fixed mantissa per setting, never an arbitrary one
    if (nvm_load) begin
      nxt_mant = (nvm_setting == 3'h0) ? otf_pkg::RESTORE_LOW
               : otf_pkg::BIN_EDGE[nvm_setting - 3'h1]; // [RL8]
      nxt_retry_bit = nvm_retry_bit;                    // [RL17]
    end
    // Sticky flags; a set in the clearing cycle wins
    nxt_cml = (cml_ff && !clear_faults) || bad_write;   // [RL9]
    nxt_ivd = (ivd_ff && !clear_faults) || bad_write;   // [RL9]
    nxt_otf = (otf_ff && !clear_faults) || trip;        // [RL11]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mant_ff      <= otf_pkg::THR_MANT_RST;
      retry_bit_ff <= otf_pkg::RETRY_BIT_RST;
      rsp_ff       <= '0;
      rsp_pulse_ff <= 1'h0;
      cml_ff       <= 1'h0;
      ivd_ff       <= 1'h0;
      otf_ff       <= 1'h0;
    end else begin
      mant_ff      <= nxt_mant;
      retry_bit_ff <= nxt_retry_bit;
      rsp_ff       <= nxt_rsp;
      rsp_pulse_ff <= nxt_rsp_pulse;
      cml_ff       <= nxt_cml;
      ivd_ff       <= nxt_ivd;
      otf_ff       <= nxt_otf;
    end
  end

  // Comparator works on the unregistered binned value, so new writes act at once
  assign hot  = die_temp >= thr_degc;                   // [RL2] [RL19] [RL7]
  assign trip = (st_ff == ST_RUN) && en_ff && hot;

  // Fault response machine
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_RUN: begin
        if (trip) begin                                 // [RL12]
          nxt_st  = retry_bit_ff ? ST_HICCUP : ST_LATCHED;
          nxt_cnt = CNT_LOAD;
        end
      end
      ST_LATCHED: begin
        if (!en_ff) begin
          nxt_st = ST_RUN;                              // [RL14]
        end
      end
      ST_HICCUP: begin
        // Dropping enable counts as commanded off
        if (!en_ff || cnt_ff == '0) begin
          nxt_st = ST_RUN;                              // [RL15]
        end else begin
          nxt_cnt = cnt_ff - CW'(1);
        end
      end
      default: begin
        nxt_st = ST_RUN;
      end
    endcase
    nxt_out_en = en_ff && (nxt_st == ST_RUN);
    nxt_shut   = nxt_st != ST_RUN;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff     <= ST_RUN;
      cnt_ff    <= '0;
      out_en_ff <= 1'h0;
      shut_ff   <= 1'h0;
      alert_ff  <= 1'h0;
      deg_ff    <= 8'h00;
    end else begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      out_en_ff <= nxt_out_en;
      shut_ff   <= nxt_shut;
      alert_ff  <= nxt_otf || nxt_cml;                  // [RL11]
      deg_ff    <= thr_degc;
    end
  end

  // Alert is open drain: pull low while any flag stands
  assign alert_out           = 1'h0;
  assign alert_oe            = alert_ff;
  assign out_enable          = out_en_ff;
  assign fault_shutdown      = shut_ff;
  assign overtemp_fault_flag = otf_ff;
  assign cml_flag            = cml_ff;
  assign ivd_flag            = ivd_ff;
  assign thr_applied_degc    = deg_ff;

  // Helper: remember command of the answer in flight
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_cmd_ff <= 8'h00;
      last_wr_ff  <= 1'h0;
    end else if (req_pulse) begin
      last_cmd_ff <= req.cmd;
      last_wr_ff  <= req.write;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_reject;
    !rsp_ff.ack && rsp_pulse_ff && cml_ff && ivd_ff;
  endsequence

  sequence seq_trip;
    otf_ff && fault_shutdown && !out_enable;
  endsequence

  thr_bad_nack_a: assert property ( // [RL9]
    req_pulse && !nvm_load && req.cmd == otf_pkg::CMD_THRESHOLD &&
    req.write && req.word && req.wdata[15:6] != 10'h040
    |=> seq_reject and mant_ff == $past(mant_ff))
    else $error("bad threshold write not refused");

  thr_store_a: assert property ( // [RL6]
    req_pulse && !nvm_load && req.cmd == otf_pkg::CMD_THRESHOLD &&
    req.write && req.word && req.wdata[15:6] == 10'h040
    |=> rsp_ff.ack ##1 mant_ff == $past(req.wdata[5:0], 2))
    else $error("threshold write not stored");

  act_reject_a: assert property ( // [RL16]
    req_pulse && !nvm_load && req.cmd == otf_pkg::CMD_ACTION &&
    req.write && !req.word && wr_sel != 3'h0 && wr_sel != 3'h7
    |=> seq_reject and $stable(retry_bit_ff))
    else $error("bad retry selection accepted");

  act_store_a: assert property ( // [RL17]
    req_pulse && !nvm_load && req.cmd == otf_pkg::CMD_ACTION &&
    req.write && !req.word && req.wdata == 16'h00bf
    |=> rsp_ff.ack && retry_bit_ff)
    else $error("restart selection not stored");

  act_read_a: assert property ( // [RL18]
    rsp_pulse_ff && !last_wr_ff && last_cmd_ff == otf_pkg::CMD_ACTION
    |-> rsp_ff.rdata[7:6] == 2'h2 &&
        rsp_ff.rdata[2:0] == rsp_ff.rdata[5:3] &&
        rsp_ff.rdata[5:3] == {3{retry_bit_ff}})
    else $error("response byte image wrong");

  fault_trip_a: assert property ( // [RL11]
    st_ff == ST_RUN && en_ff && die_temp >= thr_degc
    |=> seq_trip and alert_oe)
    else $error("fault did not shut down and alert");

  // Sticky: only an explicit clear may drop the flag and the alert
  flag_keep_a: assert property ( // [RL11]
    otf_ff && !clear_faults |=> otf_ff && alert_oe)
    else $error("fault flag dropped without clear");

  latch_hold_a: assert property ( // [RL14]
    st_ff == ST_LATCHED && en_ff |=> st_ff == ST_LATCHED)
    else $error("latched state left without enable toggle");

  latch_exit_a: assert property ( // [RL14]
    st_ff == ST_LATCHED && !en_ff |=> st_ff == ST_RUN && !out_enable)
    else $error("latch not released by enable low");

  retry_load_a: assert property ( // [RL15]
    st_ff == ST_RUN && trip && retry_bit_ff
    |=> st_ff == ST_HICCUP && cnt_ff == CNT_LOAD)
    else $error("restart delay not started");

  retry_wait_a: assert property ( // [RL15]
    st_ff == ST_HICCUP && en_ff && cnt_ff != '0
    |=> st_ff == ST_HICCUP && !out_enable)
    else $error("restart before delay expired");

  restart_on_a: assert property ( // [RL15]
    st_ff == ST_HICCUP && en_ff && cnt_ff == '0
    |=> st_ff == ST_RUN && out_enable && !fault_shutdown)
    else $error("no restart after the delay");

  restore_fix_a: assert property ( // [RL8]
    nvm_load |=> (mant_ff == 6'h1d) || (mant_ff == bin_idx + 6'h1d) ||
                 (mant_ff >= 6'h22 && bin_idx == 3'(mant_ff - 6'h1e)))
    else $error("restore gave a non fixed mantissa");

  bin_default_a: assert property ( // [RL7]
    mant_ff == 6'h24 |-> thr_degc == 8'h91 ##1 thr_applied_degc == 8'h91)
    else $error("default mantissa not at 145 C");

endmodule

/* File: src/otf_pkg.sv */
package otf_pkg;

  // Command codes on the management link
  localparam logic [7:0] CMD_THRESHOLD = 8'h4f;
  localparam logic [7:0] CMD_ACTION    = 8'h50;

  // Threshold word layout
  localparam int         THR_EXP_LSB   = 11;
  localparam int         THR_RSV_LSB   = 6;
  localparam logic [4:0] THR_EXP       = 5'h02;
  localparam logic [4:0] THR_RSV       = 5'h00;
  localparam logic [5:0] THR_MANT_RST  = 6'h24;

  // Action byte layout
  localparam int         ACT_FIX_LSB   = 6;
  localparam int         ACT_SEL_LSB   = 3;
  localparam int         ACT_DLY_LSB   = 0;
  localparam logic [1:0] ACT_FIXED     = 2'h2;
  localparam logic [2:0] RETRY_LATCH   = 3'h0;
  localparam logic [2:0] RETRY_AUTO    = 3'h7;
  localparam logic       RETRY_BIT_RST = 1'h0;

  // Binning: mantissa edges, lowest first
  localparam int              BIN_N      = 7;
  localparam logic [6:0][5:0] BIN_EDGE   = {6'h25, 6'h24, 6'h23, 6'h22,
                                            6'h20, 6'h1f, 6'h1e};
  localparam logic [7:0]      BIN_BASE_C = 8'h73;
  localparam logic [7:0]      BIN_STEP_C = 8'h05;
  localparam logic [5:0]      RESTORE_LOW = 6'h1d;

  // Restart delay
  localparam int RETRY_DELAY_MS = 52;
  localparam int CLK_FREQ_KHZ   = 100000;
  localparam int RETRY_CYCLES   = RETRY_DELAY_MS * CLK_FREQ_KHZ;

  typedef struct packed {
    logic        write;
    logic        word;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } link_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } link_rsp_t;

endpackage

/* File: src/ot_bin.sv */
`timescale 1ns/1ns
module ot_bin (
  input  wire logic [5:0] mant,
  output logic      [2:0] idx,
  output logic      [7:0] degc
);

  logic [otf_pkg::BIN_N-1:0] above;

  // One comparator per bin edge
  genvar g;
  generate
    for (g = 0; g < otf_pkg::BIN_N; g++) begin : g_edge
      assign above[g] = mant >= otf_pkg::BIN_EDGE[g];
    end
  endgenerate

  // Edges are sorted, so the count of passed edges is the bin
  always_comb begin
    idx = 3'h0;
    for (int i = 0; i < otf_pkg::BIN_N; i++) begin
      idx = idx + {2'h0, above[i]};
    end
    degc = otf_pkg::BIN_BASE_C + 8'(idx * otf_pkg::BIN_STEP_C);
  end

endmodule

/* File: src/cmd_cross.sv */
`timescale 1ns/1ns
module cmd_cross (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               lnk_clk,
  input  wire logic               lnk_rstn,
  input  wire logic               lnk_valid,
  input  otf_pkg::link_req_t      lnk_req,
  output logic                    lnk_busy,
  output logic                    lnk_done,
  output otf_pkg::link_rsp_t      lnk_rsp,
  output logic                    req_pulse,
  output otf_pkg::link_req_t      req,
  input  wire logic               rsp_pulse,
  input  otf_pkg::link_rsp_t      rsp
);

  otf_pkg::link_req_t req_ff, nxt_req;
  otf_pkg::link_rsp_t lrsp_ff, nxt_lrsp, hold_ff, nxt_hold;
  logic req_tgl_ff, nxt_req_tgl, ack_meta_ff, ack_sync_ff;
  logic ack_seen_ff, nxt_ack_seen, done_ff, nxt_done;
  logic tgl_meta_ff, tgl_sync_ff, tgl_seen_ff, ack_tgl_ff, nxt_ack_tgl;

  // Link side: hold request until the core answers
  assign lnk_busy = req_tgl_ff != ack_seen_ff;
  assign lnk_done = done_ff;
  assign lnk_rsp  = lrsp_ff;

  always_comb begin
    nxt_req      = req_ff;
    nxt_req_tgl  = req_tgl_ff;
    nxt_ack_seen = ack_sync_ff;
    nxt_done     = ack_sync_ff != ack_seen_ff;
    nxt_lrsp     = nxt_done ? hold_ff : lrsp_ff;
    if (lnk_valid && !lnk_busy) begin
      nxt_req     = lnk_req;
      nxt_req_tgl = !req_tgl_ff;
    end
  end

  always_ff @(posedge lnk_clk or negedge lnk_rstn) begin
    if (!lnk_rstn) begin
      req_ff      <= '0;
      req_tgl_ff  <= 1'h0;
      ack_meta_ff <= 1'h0;
      ack_sync_ff <= 1'h0;
      ack_seen_ff <= 1'h0;
      done_ff     <= 1'h0;
      lrsp_ff     <= '0;
    end else begin
      req_ff      <= nxt_req;
      req_tgl_ff  <= nxt_req_tgl;
      ack_meta_ff <= ack_tgl_ff;
      ack_sync_ff <= ack_meta_ff;
      ack_seen_ff <= nxt_ack_seen;
      done_ff     <= nxt_done;
      lrsp_ff     <= nxt_lrsp;
    end
  end

  // Core side: request word is stable while the toggle is in flight
  assign req_pulse = tgl_sync_ff != tgl_seen_ff;
  assign req       = req_ff;

  always_comb begin
    nxt_hold    = rsp_pulse ? rsp : hold_ff;
    nxt_ack_tgl = rsp_pulse ? !ack_tgl_ff : ack_tgl_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgl_meta_ff <= 1'h0;
      tgl_sync_ff <= 1'h0;
      tgl_seen_ff <= 1'h0;
      ack_tgl_ff  <= 1'h0;
      hold_ff     <= '0;
    end else begin
      tgl_meta_ff <= req_tgl_ff;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
      ack_tgl_ff  <= nxt_ack_tgl;
      hold_ff     <= nxt_hold;
    end
  end

endmodule

/* File: sim/link_host.sv */
`timescale 1ns/1ns
// Host on the management link, one request outstanding at a time
module link_host (
  input  wire logic          lnk_clk,
  output logic               lnk_valid,
  output otf_pkg::link_req_t lnk_req,
  input  wire logic          lnk_busy,
  input  wire logic          lnk_done,
  input  otf_pkg::link_rsp_t lnk_rsp
);
  // Idle and quiet until the first request
  initial begin
    lnk_valid = 1'b0;
    lnk_req   = '0;
  end

  // Gap models a slow host; request scrambled after the taking edge
  // so that stale fields never pass for a live request
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] cmd,
                      input logic [15:0] wdata, input int gap,
                      output logic ack, output logic [15:0] rdata);
    // Always launch just after a link edge; a hang is left to the
    // bench watchdog, which fails the run
    repeat (gap + 1) @(posedge lnk_clk);
    #1;
    lnk_valid = 1'b1;
    lnk_req   = {wr, wd, cmd, wdata};
    while (lnk_busy !== 1'b0) begin
      @(posedge lnk_clk);
      #1;
    end
    @(posedge lnk_clk);
    #1;
    lnk_valid = 1'b0;
    lnk_req   = ~lnk_req;
    while (lnk_done !== 1'b1) begin
      @(posedge lnk_clk);
      #1;
    end
    ack   = lnk_rsp.ack;
    rdata = lnk_rsp.rdata;
  endtask
endmodule

/* File: sim/tb_overtemp_fault_limit_response.sv */
`timescale 1ns/1ns
module tb_overtemp_fault_limit_response;
  localparam int         RC = 20;
  localparam logic [7:0] TH = otf_pkg::CMD_THRESHOLD;
  localparam logic [7:0] AC = otf_pkg::CMD_ACTION;
  logic               clk = 1'b0, lnk_clk = 1'b0;
  logic               rstn = 1'b0, lnk_rstn = 1'b0;
  logic               lnk_valid, lnk_busy, lnk_done;
  otf_pkg::link_req_t lnk_req;
  otf_pkg::link_rsp_t lnk_rsp;
  logic [7:0]         die_temp = 8'h00;
  logic               en_pin = 1'b0, nvm_load = 1'b0, clear_faults = 1'b0;
  logic               nvm_retry_bit = 1'b0;
  logic [2:0]         nvm_setting = 3'h0;
  logic               out_enable, fault_shutdown, overtemp_fault_flag;
  logic               cml_flag, ivd_flag, alert_out, alert_oe;
  logic [7:0]         thr_applied_degc;
  logic               ack;
  logic [15:0]        rd;
  int                 n_errors = 0;
  int                 samples_checked = 0;
  logic [5:0] mt[11] = '{6'h00, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22,
                         6'h23, 6'h24, 6'h25, 6'h3f};
  logic [7:0] dg[11] = '{8'h73, 8'h73, 8'h78, 8'h7d, 8'h82, 8'h82, 8'h87,
                         8'h8c, 8'h91, 8'h96, 8'h96};
  logic [5:0] rm[8] = '{6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h22, 6'h23, 6'h24,
                        6'h25};

  // Core clock 10 ns; link clock 15 ns with its own phase
  always #5 clk = ~clk;
  initial begin
    #3;
    forever begin
      #7 lnk_clk = 1'b1;
      #8 lnk_clk = 1'b0;
    end
  end

  overtemp_fault_limit_response #(.RETRY_CYCLES(RC))
    overtemp_fault_limit_response_i (
    .clk(clk), .rstn(rstn), .lnk_clk(lnk_clk), .lnk_rstn(lnk_rstn),
    .lnk_valid(lnk_valid), .lnk_req(lnk_req), .lnk_busy(lnk_busy),
    .lnk_done(lnk_done), .lnk_rsp(lnk_rsp), .die_temp(die_temp),
    .en_pin(en_pin), .nvm_load(nvm_load), .nvm_setting(nvm_setting),
    .nvm_retry_bit(nvm_retry_bit), .clear_faults(clear_faults),
    .out_enable(out_enable), .fault_shutdown(fault_shutdown),
    .overtemp_fault_flag(overtemp_fault_flag), .cml_flag(cml_flag),
    .ivd_flag(ivd_flag), .alert_out(alert_out), .alert_oe(alert_oe),
    .thr_applied_degc(thr_applied_degc));

  link_host link_host_i (
    .lnk_clk(lnk_clk), .lnk_valid(lnk_valid), .lnk_req(lnk_req),
    .lnk_busy(lnk_busy), .lnk_done(lnk_done), .lnk_rsp(lnk_rsp));

  // Compare and count
  task automatic check(input logic [16:0] got, input logic [16:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Access with the documented transfer size for each command
  task automatic rw(input logic w, input logic [7:0] cmd,
                    input logic [15:0] d);
    link_host_i.xfer(w, cmd == TH, cmd, d, 0, ack, rd);
  endtask

  task automatic clr;
    cyc(1);
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(1);
  endtask

  // Refused write: no ack, both flags, stored value kept
  task automatic refused(input logic wd, input logic [7:0] cmd,
                         input logic [15:0] d, input logic [15:0] keep);
    link_host_i.xfer(1'b1, wd, cmd, d, 2, ack, rd);
    check({16'h0000, ack}, 17'h00000, "nack");
    cyc(1);
    check({15'h0000, cml_flag, ivd_flag}, 17'h00003, "flags");
    rw(1'b0, cmd, 16'h0000);
    check({ack, rd}, {1'b1, keep}, "kept");
    clr();
    check({15'h0000, cml_flag, ivd_flag}, 17'h00000, "cleared");
  endtask

  // No limit here: a missing start is caught by the watchdog
  task automatic wait_on;
    while (out_enable !== 1'b1)
      cyc(1);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    lnk_rstn = 1'b1;
    cyc(2);
    check({9'h000, thr_applied_degc}, 17'h00091, "rst degc");
    rw(1'b0, TH, 16'h0000);
    check({ack, rd}, 17'h11024, "rst thr");
    rw(1'b0, AC, 16'h0000);
    check({ack, rd}, 17'h10080, "rst act");
    // Eleven mantissas stored as written, applied value binned
    for (int i = 0; i < 11; i++) begin
      rw(1'b1, TH, {10'h040, mt[i]});
      check({16'h0000, ack}, 17'h00001, "thr wr");
      rw(1'b0, TH, 16'h0000);
      check({ack, rd}, {7'h44, 4'h0, mt[i]}, "thr rd");
      cyc(2);
      check({9'h000, thr_applied_degc}, {9'h000, dg[i]}, "bin");
    end
    // Read-only threshold bits and wrong transfer size
    refused(1'b1, TH, 16'h0825, 16'h103f);
    refused(1'b1, TH, 16'h1065, 16'h103f);
    refused(1'b1, TH, 16'hf03f, 16'h103f);
    refused(1'b0, TH, 16'h0024, 16'h103f);
    // Unsupported retry codes and inconsistent fixed bits
    for (int s = 1; s < 7; s++)
      refused(1'b0, AC, {10'h002, s[2:0], s[2:0]}, 16'h0080);
    refused(1'b0, AC, 16'h00b8, 16'h0080);
    refused(1'b0, AC, 16'h00ff, 16'h0080);
    refused(1'b0, AC, 16'h003f, 16'h0080);
    link_host_i.xfer(1'b0, 1'b0, 8'h51, 16'h0000, 0, ack, rd);
    check({15'h0000, ack, ivd_flag}, 17'h00000, "unknown cmd");
    rw(1'b1, AC, 16'h00bf);
    rw(1'b0, AC, 16'h0000);
    check({ack, rd}, 17'h100bf, "act auto");
    // Restore each supported setting and the retry bit
    for (int k = 0; k < 8; k++) begin
      cyc(1);
      nvm_setting = k[2:0];
      nvm_retry_bit = k[0];
      nvm_load = 1'b1;
      cyc(1);
      nvm_load = 1'b0;
      cyc(2);
      check({9'h000, thr_applied_degc}, 17'h73 + 17'h5 * k, "nvm");
      rw(1'b0, TH, 16'h0000);
      check({ack, rd}, {7'h44, 4'h0, rm[k]}, "nvm thr");
      rw(1'b0, AC, 16'h0000);
      check({ack, rd}, {9'h100, k[0] ? 8'hbf : 8'h80}, "nvm act");
    end
    // Latch-off: trips at the threshold, held until enable toggles
    rw(1'b1, TH, 16'h1024);
    rw(1'b1, AC, 16'h0080);
    cyc(1);
    en_pin = 1'b1;
    die_temp = 8'h90;
    wait_on();
    cyc(4);
    check({12'h000, overtemp_fault_flag, fault_shutdown, out_enable,
           alert_oe, alert_out}, 17'h00004, "below");
    die_temp = 8'h91;
    cyc(1);
    check({12'h000, overtemp_fault_flag, fault_shutdown, out_enable,
           alert_oe, alert_out}, 17'h0001a, "trip");
    die_temp = 8'h00;
    cyc(30);
    check({15'h0000, fault_shutdown, out_enable}, 17'h00002,
          "latch");
    en_pin = 1'b0;
    cyc(4);
    en_pin = 1'b1;
    wait_on();
    check({14'h0000, overtemp_fault_flag, fault_shutdown, out_enable},
          17'h00005, "relaunch");
    clr();
    check({15'h0000, overtemp_fault_flag, alert_oe}, 17'h00000,
          "clr");
    // Auto restart, twice; second threshold written while running
    rw(1'b1, AC, 16'h00bf);
    for (int j = 0; j < 2; j++) begin
      if (j == 1)
        rw(1'b1, TH, 16'h101e);
      cyc(2);
      die_temp = j == 1 ? 8'h78 : 8'h91;
      cyc(1);
      check({15'h0000, fault_shutdown, out_enable}, 17'h00002,
            "auto trip");
      die_temp = 8'h00;
      // Last waiting cycle, then the exact restart edge
      cyc(RC - 1);
      check({16'h0000, out_enable}, 17'h00000, "hold off");
      cyc(1);
      check({15'h0000, fault_shutdown, out_enable}, 17'h00001,
            "restart");
    end
    finish_test();
  end
endmodule
